// ==== core/synth_ctrl_regs.vh ====
// constants for the synthesizer control word map: address codes, field positions, reset values
// assumes 24-bit words shifted msb first, latched on the rising edge of the load strobe
// Functional notes
// - The quick-start values select a third-order modulator, a 12-bit modulus, no dithering and no fast-lock.
// - Lock needs only the first four words; the other four only tune spurs, noise and lock time.
// - Each word carries 20 payload bits above its address, except the main divider word with 23.
// - The main divider word is chosen by address bit 0 alone being zero.
// - In the main divider word, bits 12..1 are the low fraction and bits 23..13 the 11-bit N count.
// - The full numerator joins bits 13..4 from the extended-fraction word to the low 12 bits, gated by enable bit 1.
// - The main counter offers a 16/17/20/21 and a 32/33/36/37 quadruple-modulus prescaler.
// - The divide value is N = P*c + 4*b + a with P the base modulus of the chosen prescaler.
// - With the small prescaler, the spare upper bit b[2] of the b count is left to the modulator for its own modulation.
// - Words arrive msb first and the load strobe rising edge moves them into the addressed latch.
// - Bit 0 low selects the main word; odd codes 0011 to 1111 select words one to seven.
// - Writing the main word restarts the lock-detect and fast-lock counters without touching stored values.
// - Prescaler select 0 picks 16/17/20/21 and 1 picks 32/33/36/37.
`ifndef SYNTH_CTRL_REGS_VH
`define SYNTH_CTRL_REGS_VH
`define WORD_W 24
`define ADDR_W 4
`define PAYLOAD_W 20
`define MAIN_PAYLOAD_W 23
`define ADDR_WORD1 4'h3
`define ADDR_WORD2 4'h5
`define ADDR_WORD3 4'h7
`define ADDR_WORD4 4'h9
`define ADDR_WORD5 4'hB
`define ADDR_WORD6 4'hD
`define ADDR_WORD7 4'hF
`define N_COUNT_HI 23
`define N_COUNT_LO 13
`define FRAC_LO_HI 12
`define FRAC_LO_LO 1
`define ORDER_HI 15
`define ORDER_LO 14
`define RANDOMIZER_STRENGTH_HI 17
`define RANDOMIZER_STRENGTH_LO 16
`define PRESC_BIT 22
`define ACCESS_HI 23
`define ACCESS_LO 20
`define EXT_FRAC_BIT 1
`define FASTLOCK_BIT 3
`define FRAC_HI_HI 13
`define FRAC_HI_LO 4
`define P_SMALL 6'h10
`define P_LARGE 6'h20
// quick-start reset content of the main, denominator, access and modulator words
`define RST_WORD0 24'h000000
`define RST_WORD1 24'h000003
`define RST_WORD3 24'h000007
`define RST_WORD4 24'h10C709
`endif

// ==== core/synth_control_word_map.v ====
// synthesizer control word map: three-wire serial shifter, eight word latches, N divide decode
// assumes the host serial clock, data and load strobe are asynchronous pins sampled by clk_i
`timescale 1ns/1ps
`include "synth_ctrl_regs.vh"
module synth_control_word_map #(
  parameter SYNC_STAGES = 2
) (
  input wire clk_i, // 40 MHz core clock
  input wire reset_i, // async reset, active high
  input wire ser_clk_i, // host serial clock pin
  input wire ser_data_i, // host serial data pin
  input wire load_strobe_i, // load strobe pin
  output reg [10:0] main_n_count_o, // raw 11-bit N field
  output reg [21:0] main_frac_num_o, // full fractional numerator
  output reg [21:0] main_frac_den_o, // full fractional denominator
  output reg [5:0] main_ref_div_o, // reference divider
  output reg main_prescaler_sel_o, // 0 small, 1 large prescaler
  output reg main_powerdown_o, // main loop power-down bit
  output reg [3:0] main_pump_gain_o, // charge pump gain
  output reg [1:0] modulator_order_o, // modulator order code
  output reg [1:0] randomizer_strength_o, // dither strength
  output reg fastlock_en_o, // fast-lock enable
  output reg [11:0] main_divide_o, // computed divide value N
  output reg [1:0] spare_b_bit_o, // spare b[2] handed to modulator in bit 0, bit 1 zero
  output reg counters_restart_o, // one-cycle restart pulse
  output reg [7:0] word_loaded_o // sticky: word k written since reset
);
  // pin synchronisers: first stage read only by the second
  // bit 0 serial clock, bit 1 serial data, bit 2 load strobe
  reg [2:0] sync1_ff;
  reg [2:0] sync2_ff;
  reg sclk_prev_ff;
  reg le_prev_ff;
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
      sclk_prev_ff <= 1'h0;
      le_prev_ff <= 1'h0;
    end else begin
      sync1_ff <= {load_strobe_i, ser_data_i, ser_clk_i};
      sync2_ff <= sync1_ff;
      sclk_prev_ff <= sync2_ff[0];
      le_prev_ff <= sync2_ff[2];
    end
  end
  // edge history resets low, the idle level of both pins, so no false edge follows reset;
  // data needs no edge history and stays aligned with the serial clock path
  wire sclk_rise = sync2_ff[0] & ~sclk_prev_ff;
  wire le_rise = sync2_ff[2] & ~le_prev_ff;
  // msb-first shifter; the last 24 bits before the strobe form the word
  // extra bits fall off the top, so an overlong frame keeps only its last 24 bits
  reg [`WORD_W-1:0] shift_ff;
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      shift_ff <= 24'h000000;
    end else if (sclk_rise) begin
      shift_ff <= {shift_ff[`WORD_W-2:0], sync2_ff[1]};
    end
  end
  // address decode: bit 0 low wins before any upper bits are looked at
  // every odd code maps to exactly one latch, so no strobe is ever lost
  wire [3:0] addr = shift_ff[`ADDR_W-1:0];
  reg [7:0] sel;
  always @* begin
    sel = 8'h00;
    if (!addr[0]) begin
      sel[0] = 1'b1;
    end else if (addr == `ADDR_WORD1) begin
      sel[1] = 1'b1;
    end else if (addr == `ADDR_WORD2) begin
      sel[2] = 1'b1;
    end else if (addr == `ADDR_WORD3) begin
      sel[3] = 1'b1;
    end else if (addr == `ADDR_WORD4) begin
      sel[4] = 1'b1;
    end else if (addr == `ADDR_WORD5) begin
      sel[5] = 1'b1;
    end else if (addr == `ADDR_WORD6) begin
      sel[6] = 1'b1;
    end else begin
      sel[7] = 1'b1;
    end
  end
  // eight word latches; reset to quick-start content so lock needs only words 0..3
  reg [`WORD_W-1:0] word_ff [0:7];
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_word
      // words with no quick-start value come up zero and need a host write before use
      localparam [`WORD_W-1:0] RST_VAL = (gi == 0) ? `RST_WORD0 :
        (gi == 1) ? `RST_WORD1 :
        (gi == 3) ? `RST_WORD3 :
        (gi == 4) ? `RST_WORD4 : 24'h000000;
      always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
          word_ff[gi] <= RST_VAL;
        end else if (le_rise && sel[gi]) begin
          word_ff[gi] <= shift_ff;
        end
      end
    end
  endgenerate
  // sticky record of which words were written
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      word_loaded_o <= 8'h00;
    end else if (le_rise) begin
      word_loaded_o <= word_loaded_o | sel;
    end
  end
  // restart pulse for lock-detect and fast-lock counters; stored values untouched
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      counters_restart_o <= 1'b0;
    end else begin
      counters_restart_o <= le_rise & sel[0];
    end
  end
  // latch views; the payload is 23 bits in word 0 and 20 bits in the rest
  wire [`WORD_W-1:0] w0 = word_ff[0];
  wire [`WORD_W-1:0] w1 = word_ff[1];
  wire [`WORD_W-1:0] w3 = word_ff[3];
  wire [`WORD_W-1:0] w4 = word_ff[4];
  wire [`WORD_W-1:0] w5 = word_ff[5];

  // word 0: N count above the low numerator; bit 0 is the address and carries no data
  wire [10:0] n_raw = w0[`N_COUNT_HI:`N_COUNT_LO];
  wire [11:0] fn_lo = w0[`FRAC_LO_HI:`FRAC_LO_LO];

  // word 1: power-down, prescaler select, reference divider, low denominator
  wire w1_powerdown = w1[23];
  wire presc = w1[`PRESC_BIT];
  wire [5:0] w1_ref_div = w1[21:16];
  wire [11:0] fd_lo = w1[15:4];

  // word 3: access enables above the pump gain
  wire [3:0] access = w3[`ACCESS_HI:`ACCESS_LO];
  wire [3:0] w3_pump_gain = w3[19:16];
  wire ext_en = access[`EXT_FRAC_BIT]; // one enable gates both upper parts
  wire fastlock_en = access[`FASTLOCK_BIT];

  // word 4: modulator order and dither strength
  wire [1:0] order_code = w4[`ORDER_HI:`ORDER_LO];
  wire [1:0] randomizer_strength_code = w4[`RANDOMIZER_STRENGTH_HI:`RANDOMIZER_STRENGTH_LO];

  // word 5: upper numerator and denominator, zero unless the extension is enabled,
  // so a stale word 5 cannot skew a 12-bit setup
  wire [9:0] fn_hi = ext_en ? w5[`FRAC_HI_HI:`FRAC_HI_LO] : 10'h000;
  wire [9:0] fd_hi = ext_en ? w5[23:14] : 10'h000;

  // N splits into c (6 bits), b (3 bits) and a (2 bits)
  wire [5:0] c_cnt = n_raw[10:5];
  wire [2:0] b_cnt = n_raw[4:2];
  wire [1:0] a_cnt = n_raw[1:0];

  // the small prescaler only needs b[1:0]; b[2] is left spare for the modulator
  wire [5:0] p_base = presc ? `P_LARGE : `P_SMALL;
  wire [2:0] b_eff = presc ? b_cnt : {1'b0, b_cnt[1:0]};
  wire spare_b = ~presc & b_cnt[2];

  // N = P*c + 4*b + a; 12 bits hold the largest value, 63*32 + 28 + 3
  // an illegal N is still computed: keeping N in range is the host's duty
  wire [11:0] c_term = c_cnt * p_base;
  wire [11:0] b_term = {7'h00, b_eff, 2'h0};
  wire [11:0] a_term = {10'h000, a_cnt};
  wire [11:0] nxt_divide = c_term + b_term + a_term;

  // N count, divide value and spare b bit follow word 0 one cycle after the latch
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      main_n_count_o <= 11'h000;
      main_divide_o <= 12'h000;
      spare_b_bit_o <= 2'h0;
    end else begin
      main_n_count_o <= n_raw;
      main_divide_o <= nxt_divide;
      spare_b_bit_o <= {1'b0, spare_b};
    end
  end

  // full numerator and denominator: upper parts from word 5, lower from words 0 and 1
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      main_frac_num_o <= 22'h000000;
      main_frac_den_o <= 22'h000000;
    end else begin
      main_frac_num_o <= {fn_hi, fn_lo};
      main_frac_den_o <= {fd_hi, fd_lo};
    end
  end

  // word 1 fields; the prescaler select also steers the divide value above
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      main_powerdown_o <= 1'b0;
      main_prescaler_sel_o <= 1'b0;
      main_ref_div_o <= 6'h00;
    end else begin
      main_powerdown_o <= w1_powerdown;
      main_prescaler_sel_o <= presc;
      main_ref_div_o <= w1_ref_div;
    end
  end

  // word 3 fields; fast-lock stays off until the host sets its enable
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      main_pump_gain_o <= 4'h0;
      fastlock_en_o <= 1'b0;
    end else begin
      main_pump_gain_o <= w3_pump_gain;
      fastlock_en_o <= fastlock_en;
    end
  end

  // word 4 fields; quick-start content gives third order and no dither
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      modulator_order_o <= 2'h0;
      randomizer_strength_o <= 2'h0;
    end else begin
      modulator_order_o <= order_code;
      randomizer_strength_o <= randomizer_strength_code;
    end
  end
endmodule

// ==== dv/synth_host_model.sv ====
// host model driving the three-wire programming port
// assumes callers enter send just after a falling edge of clk_i
`timescale 1ns/1ps
module synth_host_model (
  input wire clk_i, // bench clock
  output logic ser_clk_o = 1'h0, // serial clock, idle low
  output logic ser_data_o = 1'h0, // serial data
  output logic load_strobe_o = 1'h0 // load strobe
);
  // 8 clocks a bit keeps every edge well clear of the 3-clock sampling path
  task automatic send(input logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin // msb first, 24 bits
      ser_data_o = w[i];
      repeat (4) @(negedge clk_i);
      ser_clk_o = 1'h1;
      repeat (4) @(negedge clk_i);
      ser_clk_o = 1'h0;
    end
    ser_data_o = ~w[0]; // line no longer holds the last bit
    repeat (4) @(negedge clk_i);
    load_strobe_o = 1'h1; // rising edge moves the word
    repeat (8) @(negedge clk_i);
    load_strobe_o = 1'h0;
    repeat (4) @(negedge clk_i);
  endtask
endmodule

// ==== dv/synth_control_word_map_asserts.sv ====
// checker for the control word map: divide decode, restart pulse, load timing
// assumes it is bound to the map and sees only its ports
`timescale 1ns/1ps
module synth_control_word_map_asserts (
  input wire clk_i, // clock
  input wire reset_i, // reset
  input wire load_strobe_i, // strobe pin
  input wire [10:0] main_n_count_o, // n field
  input wire [21:0] main_frac_den_o, // denominator
  input wire [3:0] main_pump_gain_o, // pump gain
  input wire main_prescaler_sel_o, // prescaler
  input wire [1:0] randomizer_strength_o, // dither
  input wire [1:0] modulator_order_o, // modulator order
  input wire fastlock_en_o, // fast-lock
  input wire [11:0] main_divide_o, // divide
  input wire [1:0] spare_b_bit_o, // spare b
  input wire counters_restart_o, // restart
  input wire [7:0] word_loaded_o // loaded flags
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  wire [10:0] n = main_n_count_o;
  // the small prescaler ignores b[2], which goes to the modulator
  wire [11:0] c_part = main_prescaler_sel_o ? {1'h0, n[10:5], 5'h00} : {2'h0, n[10:5], 4'h0};
  wire [11:0] b_part = main_prescaler_sel_o ? {7'h00, n[4:2], 2'h0} : {8'h00, n[3:2], 2'h0};
  chk_divide_value: assert property (
    $stable(n) && $stable(main_prescaler_sel_o) |-> main_divide_o == c_part + b_part + n[1:0])
    else $error("divide value wrong");
  chk_spare_b: assert property (
    !main_prescaler_sel_o && $stable(n) |-> spare_b_bit_o[0] == n[4]) else $error("spare bit");
  chk_restart_once: assert property (counters_restart_o |=> !counters_restart_o)
    else $error("restart too long");
  // the restart pulse comes with the latch, one cycle ahead of the field outputs
  chk_restart_cause: assert property ($changed(n) |-> $past(counters_restart_o))
    else $error("no restart");
  chk_restart_keeps: assert property (
    counters_restart_o |=> $stable(main_frac_den_o) && $stable(main_pump_gain_o))
    else $error("restart changed fields");
  chk_load_timing: assert property (
    $changed(n) |-> $past(load_strobe_i, 3) || $past(load_strobe_i, 6)) else $error("no strobe");
  chk_loaded_sticky: assert property (
    (word_loaded_o & $past(word_loaded_o)) == $past(word_loaded_o)) else $error("flag fell");
  chk_quick_start: assert property (!word_loaded_o[3] && !word_loaded_o[4]
    |-> randomizer_strength_o == 2'h0 && !fastlock_en_o
      && (modulator_order_o == 2'h3 || $past(reset_i))) else $error("quick start");
  cov_restart: cover property (counters_restart_o);
  cov_large: cover property (main_prescaler_sel_o && counters_restart_o);
  cov_all: cover property (word_loaded_o == 8'hFF);
endmodule
bind synth_control_word_map synth_control_word_map_asserts i_chk (.*);

// ==== dv/synth_control_word_map_test.sv ====
// bench for the control word map; a host model shifts words in
// assumes the map, its checker and the host model are compiled first
`timescale 1ns/1ps
`include "synth_ctrl_regs.vh"
module synth_control_word_map_test;
  logic clk_i = 1'h0;
  logic reset_i = 1'h1;
  wire ser_clk_i, ser_data_i, load_strobe_i, main_prescaler_sel_o, main_powerdown_o;
  wire fastlock_en_o, counters_restart_o;
  wire [10:0] main_n_count_o;
  wire [21:0] main_frac_num_o, main_frac_den_o;
  wire [5:0] main_ref_div_o;
  wire [3:0] main_pump_gain_o;
  wire [1:0] modulator_order_o, randomizer_strength_o, spare_b_bit_o;
  wire [11:0] main_divide_o;
  wire [7:0] word_loaded_o;
  logic [23:0] lfsr = 24'h000057, w, w5;
  logic [21:0] den;
  int n_mismatch = 0, tests_run = 0, n_restart = 0;
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) if (counters_restart_o === 1'h1) n_restart++;
  synth_host_model i_host (.clk_i(clk_i), .ser_clk_o(ser_clk_i), .ser_data_o(ser_data_i),
    .load_strobe_o(load_strobe_i));
  synth_control_word_map i_dut (.*);
  function automatic logic [23:0] rnd();
    lfsr = {lfsr[22:0], lfsr[23] ^ lfsr[22] ^ lfsr[21] ^ lfsr[16]};
    return lfsr;
  endfunction
  // divide value from packed counts; small prescaler uses b[1:0] only
  function automatic logic [11:0] exp_div(input logic s, input logic [10:0] n);
    return s ? n[10:5] * 12'h020 + n[4:2] * 12'h004 + n[1:0]
      : n[10:5] * 12'h010 + n[3:2] * 12'h004 + n[1:0];
  endfunction
  task automatic check(input string what, input logic [23:0] got, input logic [23:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge clk_i);
    reset_i = 1'h0;
    repeat (2) @(negedge clk_i);
    check("quick", {word_loaded_o, randomizer_strength_o, fastlock_en_o}, 24'h0);
    check("order", modulator_order_o, 24'h000003);
    $display("reset test done");
    // odd address codes 0011 to 1111 once, random payloads except fixed parts of words 4 and 7
    for (int k = 1; k < 8; k++) begin
      w = rnd();
      if (k == 4) w = `RST_WORD4 | {6'h00, w[17:16], 16'h0000};
      if (k == 7) w = 24'h00090F;
      w[3:0] = 4'(2 * k + 1);
      i_host.send(w);
      check("loaded", word_loaded_o, (24'h2 << k) - 24'h2);
      if (k == 1) check("w1", {main_powerdown_o, main_prescaler_sel_o, main_ref_div_o,
        main_frac_den_o[11:0]}, w[23:4]);
      if (k == 3) check("w3", {fastlock_en_o, main_pump_gain_o}, {w[23], w[19:16]});
      if (k == 4) check("w4", {modulator_order_o, randomizer_strength_o},
        {w[15:14], w[17:16]});
      if (k == 5) w5 = w;
    end
    check("restart", n_restart, 0);
    $display("word map test done");
    // main word with both prescalers, extension on and off, 1023 and 49 corners
    for (int k = 0; k < 10; k++) begin
      w = rnd();
      i_host.send({w[23], k[0], w[21:4], 4'h3});
      i_host.send({w[23:22], k[1], w[20:4], 4'h7});
      den = main_frac_den_o;
      // c of 8 or more stays above b and a; corners are 1023 and 49 on the small prescaler
      w = {k == 0 ? 11'h7EF : k == 2 ? 11'h061 :
        {w[23:18] | 6'h08, w[17:13]}, w[12:1], 1'h0};
      i_host.send(w);
      check("n", main_n_count_o, w[23:13]);
      check("num", main_frac_num_o, {k[1] ? w5[13:4] : 10'h000, w[12:1]});
      check("div", main_divide_o, exp_div(k[0], w[23:13]));
      check("spare", spare_b_bit_o[0] | k[0], w[17] | k[0]);
      check("restart", n_restart, k + 1);
      check("den", main_frac_den_o, den);
    end
    $display("main word test done");
    complete_run();
  end
  // about 8000 clocks of traffic; twice that means a hang
  initial begin
    #400000;
    n_mismatch++;
    complete_run();
  end
endmodule
